// *** pkg/purs_pkg.sv ***
package purs_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned EXTRA_DELAY_MS = 50;
  localparam int unsigned EXTRA_DELAY_CYC = (CLK_FREQ_HZ / 1000) * EXTRA_DELAY_MS;
  localparam int unsigned CNT_W = 23;
  // cycles of settling after power-on reset release before pins are judged
  localparam int unsigned POR_SETTLE_CYC = 4;

  // ****************************************************************
  // modes and states
  // ****************************************************************
  typedef enum logic {PURS_MODE_IMMEDIATE, PURS_MODE_DELAYED} purs_mode_e;

  typedef enum {PURS_ST_POR, PURS_ST_DELAY, PURS_ST_WAIT_PINS, PURS_ST_RUN} purs_state_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic chip_enable_low;
    logic config_request;
    logic status_line;
  } purs_ctrl_pins_s;

  typedef struct packed {
    logic done_out;
    logic done_oe_n;
  } purs_done_pin_s;

endpackage

// *** design/purs_sequencer.sv ***
// Functional notes
// - power-on reset clears every register except the user reset, which it sets high, in both power-up modes.
// - immediate mode: done indicator released to high impedance after reset, pins permitting.
// - delayed mode holds reset an extra 50 ms, otherwise as immediate.
// - during the extra delay the done indicator is driven low, then released.
// - fixed function; no configuration bitstream accepted or needed.
// - no emulation, remote upgrade or encryption; only two power-up modes.
module purs_sequencer
  import purs_pkg::*;
#(
  parameter purs_mode_e MODE = PURS_MODE_IMMEDIATE,
  parameter int unsigned DELAY_CYC = EXTRA_DELAY_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire purs_ctrl_pins_s CTRL_PINS,
  output logic DONE_OUT,
  output logic DONE_OE_N,
  output logic USER_RESET,
  output logic USER_READY
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // board levels are asynchronous; only the second stage feeds logic
  purs_ctrl_pins_s sync1_r;
  purs_ctrl_pins_s sync1_nxt;
  purs_ctrl_pins_s sync2_r;
  purs_ctrl_pins_s sync2_nxt;

  always_comb
  begin
    sync1_nxt = CTRL_PINS;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic pins_ok(input purs_ctrl_pins_s p);
    pins_ok = !p.chip_enable_low && p.config_request && p.status_line;
  endfunction

  // last cycle of a count that runs len cycles from zero
  function automatic logic count_done(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] len
  );
    count_done = (cnt >= len - CNT_W'(1));
  endfunction

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  purs_state_e state_r;
  purs_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic por_end;
  logic delay_end;

  // end-of-count flags shared by state and counter logic
  always_comb
  begin
    por_end = count_done(cnt_r, CNT_W'(POR_SETTLE_CYC));
    delay_end = count_done(cnt_r, CNT_W'(DELAY_CYC));
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PURS_ST_POR:
      begin
        if (por_end)
        begin
          if (MODE == PURS_MODE_DELAYED)
            state_nxt = PURS_ST_DELAY;
          else
            state_nxt = PURS_ST_WAIT_PINS;
        end
      end
      PURS_ST_DELAY:
      begin
        if (delay_end)
          state_nxt = PURS_ST_WAIT_PINS;
      end
      PURS_ST_WAIT_PINS:
      begin
        if (pins_ok(sync2_r))
          state_nxt = PURS_ST_RUN;
      end
      PURS_ST_RUN:
      begin
        state_nxt = PURS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_r <= PURS_ST_POR;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // settle and delay counter
  // ****************************************************************
  always_comb
  begin
    cnt_nxt = '0;
    unique case (state_r)
      PURS_ST_POR:
      begin
        if (!por_end)
          cnt_nxt = cnt_r + CNT_W'(1);
      end
      PURS_ST_DELAY:
      begin
        if (!delay_end)
          cnt_nxt = cnt_r + CNT_W'(1);
      end
      PURS_ST_WAIT_PINS,
      PURS_ST_RUN:
        cnt_nxt = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // done indicator and user-side outputs
  // ****************************************************************
  logic run_nxt;
  logic done_out_r;
  logic done_out_nxt;
  logic done_oe_n_r;
  logic done_oe_n_nxt;
  logic user_reset_r;
  logic user_reset_nxt;
  logic user_ready_r;
  logic user_ready_nxt;

  always_comb
  begin
    run_nxt = (state_nxt == PURS_ST_RUN);
    done_out_nxt = 1'b0;
    done_oe_n_nxt = run_nxt;
    user_reset_nxt = !run_nxt;
    user_ready_nxt = run_nxt;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      done_out_r <= 1'b0;
      done_oe_n_r <= 1'b0;
      user_reset_r <= 1'b1;
      user_ready_r <= 1'b0;
    end
    else
    begin
      done_out_r <= done_out_nxt;
      done_oe_n_r <= done_oe_n_nxt;
      user_reset_r <= user_reset_nxt;
      user_ready_r <= user_ready_nxt;
    end
  end

  // ****************************************************************
  // top-level outputs
  // ****************************************************************
  assign DONE_OUT = done_out_r;
  assign DONE_OE_N = done_oe_n_r;
  assign USER_RESET = user_reset_r;
  assign USER_READY = user_ready_r;

endmodule

// *** tb/purs_checker.sv ***
module purs_checker
  import purs_pkg::*;
#(
  parameter purs_mode_e MODE = PURS_MODE_IMMEDIATE,
  parameter int unsigned DELAY_CYC = 20
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire purs_ctrl_pins_s CTRL_PINS,
  input wire logic DONE_OUT,
  input wire logic DONE_OE_N,
  input wire logic USER_RESET,
  input wire logic USER_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  // edge index, counted from reset release, at which the release is first seen
  localparam int unsigned REL_CYC = POR_SETTLE_CYC + 1
    + (MODE == PURS_MODE_DELAYED ? DELAY_CYC : 0);
  int unsigned cnt_r;
  int unsigned cnt_nxt;
  always_comb cnt_nxt = RST ? 0 : cnt_r + 1;
  always_ff @(posedge SYS_CLK) cnt_r <= cnt_nxt;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence held_s;
    !DONE_OE_N && !DONE_OUT && USER_RESET && !USER_READY;
  endsequence
  sequence released_s;
    DONE_OE_N && !DONE_OUT && !USER_RESET && USER_READY;
  endsequence
  a_rst_clears: assert property (disable iff (1'b0) RST |=> held_s) else $error("not held");
  a_done_low: assert property (!DONE_OE_N |-> !DONE_OUT) else $error("done high");
  a_ready_sticky: assert property (USER_READY |=> USER_READY) else $error("ready lost");
  a_pins_gate: assert property ($rose(USER_READY) |-> $past(CTRL_PINS, 3) == 3'h3)
    else $error("bad pins");
  a_no_early: assert property ($rose(USER_READY) |-> cnt_r >= REL_CYC)
    else $error("early release");
  a_delay_held: assert property (cnt_r < REL_CYC |-> held_s)
    else $error("released during delay");
  a_release_whole: assert property ($rose(USER_READY) |-> released_s)
    else $error("partial release");
endmodule

// *** tb/purs_board.sv ***
module purs_board
  import purs_pkg::*;
(
  input wire logic [1:0] fault,
  output purs_ctrl_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // static board levels; a nonzero fault breaks one of them
  always_comb
  begin
    pins.chip_enable_low = (fault == 2'h1);
    pins.config_request = (fault != 2'h2);
    pins.status_line = (fault != 2'h3);
  end
endmodule

// *** tb/tb.sv ***
module tb;
  import purs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  localparam int unsigned D_CYC = 20;
  logic [1:0] fault = 2'h0;
  purs_ctrl_pins_s pins;
  wire [3:0] oi;
  wire [3:0] od;
  int n_errors = 0;
  int compares = 0;
  initial forever #5 clk = ~clk;
  purs_board brd (.fault(fault), .pins(pins));
  purs_sequencer DUT (.SYS_CLK(clk), .RST(rst), .CTRL_PINS(pins), .DONE_OUT(oi[3]),
    .DONE_OE_N(oi[2]), .USER_RESET(oi[1]), .USER_READY(oi[0]));
  purs_sequencer #(.MODE(PURS_MODE_DELAYED), .DELAY_CYC(D_CYC)) DUT_D (.SYS_CLK(clk),
    .RST(rst), .CTRL_PINS(pins), .DONE_OUT(od[3]), .DONE_OE_N(od[2]),
    .USER_RESET(od[1]), .USER_READY(od[0]));
  task chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task t_reset;
    rst = 1;
    repeat (16) @(negedge clk);
    rst = 0;
    chk({oi, od}, 8'h22);
  endtask
  task t_good;
    int ci;
    int cd;
    fault = 2'h0;
    t_reset;
    ci = 0;
    cd = 0;
    for (int c = 1; c < 60; c++)
    begin
      @(negedge clk);
      if (ci == 0 && oi[0]) ci = c;
      if (cd == 0 && od[0]) cd = c;
      if (ci == c) chk(od[3:2], 0);
    end
    chk(ci, POR_SETTLE_CYC + 1);
    chk(cd - ci, D_CYC);
    chk({oi, od}, 8'h55);
    $display("good done");
  endtask
  task t_pins;
    for (int f = 1; f < 4; f++)
    begin
      fault = 2'(f);
      t_reset;
      repeat (40) @(negedge clk);
      chk({oi, od}, 8'h22);
      fault = 2'h0;
      repeat (40) @(negedge clk);
      chk({oi, od}, 8'h55);
    end
    $display("pins done");
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    t_good;
    t_pins;
    report_and_stop;
  end
  initial
  begin
    #20us;
    n_errors++;
    report_and_stop;
  end
endmodule
bind purs_sequencer purs_checker #(.MODE(MODE), .DELAY_CYC(DELAY_CYC)) chk_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .CTRL_PINS(CTRL_PINS), .DONE_OUT(DONE_OUT),
  .DONE_OE_N(DONE_OE_N), .USER_RESET(USER_RESET), .USER_READY(USER_READY));
